// ---- src/sdw_ctrl.sv ----
// Serial drum sequencing, word transfer, parity and write control.
// Assumes drumPulse is one clk wide per clock-track pulse, readBit is
// valid at drumPulse, and the host answers brkOut.req with brkAck.
// Behaviour
// - Sequencer is in exactly one of idle, wait, running, done.
// - Normal transfer steps idle, wait, running, done in order.
// - Holding buffer is 18 bits, swapped whole with host and shifter.
// - Shift buffer is 18 bits, serial in on read, serial out on write.
// - Written ones are counted and a 19th bit makes the count odd.
// - On read, a word with an even count of ones sets parity error.
// - Error shown is parity error or late data error.
// - Word control holds direction, raises break requests, flags errors.
// - Setup picks direction, forces idle, loads address, sets request on write.
// - Host break loads holding buffer on write; address counter counts up in the same cycle.
// - Block command loads track and sector, reloads shifter, starts delay.
// - When the settling delay ends, enter wait for index.
// - First pulse after the track gap moves wait to running.
// - Outside running no phase pulses, so nothing shifts or writes.
// - In running, pulses shift, and on write they toggle the write data flop.
// - On sector mismatch all steps run but the writer stays off.
// - After 19 bits reload shifter, bump count, on match enable, request.
// - Writing runs to the track gap, whose start sets done.
// - Sector 0 block command at once requests a word and enables writer.
// - On read holding starts empty, takes words, passes them to core.
// - Address counter is 16 bits, loaded before block, bumped per word.
// - Block address is 9 bits, LSB sector, bumped after clean block.
// - A word slot is 18 data, one parity and one blank pulse.
`timescale 1ns/1ps
module sdw_ctrl
  import sdw_pkg::*;
#(
  parameter int WORD_W = WORD_BITS,
  parameter int ADDR_W = ADDR_BITS,
  parameter int SETTLE = SETTLE_CYC,
  parameter int GAP    = GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        drumPulse,
  input  wire logic        readBit,
  input  wire logic        brkAck,
  input  wire logic [17:0] brkWordIn,
  output sdw_brk_s         brkOut,
  output sdw_head_s        headOut,
  output logic             errorOut
);
  // The datapath is fixed by the word format; other sizes are refused
  if (WORD_W != WORD_BITS || ADDR_W != ADDR_BITS) begin : g_bad_width
    $error("sdw_ctrl: word and address widths are fixed");
  end
  if (SETTLE < 2 || SETTLE > 65535 || GAP < 2 || GAP > 255) begin : g_bad_t
    $error("sdw_ctrl: timing counts out of range");
  end
  localparam logic [15:0] SETTLE16 = 16'(SETTLE);
  localparam logic [7:0]  GAP8     = 8'(GAP);
  sdw_state_e        state;
  logic [7:0]        busAddr;
  logic [31:0]       readData;
  logic [7:0]        idleCnt;
  logic [4:0]        pos;
  logic [15:0]       settleCnt;
  logic [17:0]       shiftBuf;
  logic [17:0]       holding;
  logic [15:0]       coreAddr;
  logic [8:0]        blk;
  // Single-bit control flops
  logic              busWrite, busPend, phB, parityAcc, writeFf, writerEn;
  logic              reqFlag, readMode, dirOut, sc, perr, derr;
  // Bus strokes and drum timing events
  logic              accept, cmdSetup, cmdBlock, cmdCont, gapped;
  logic              indexPulse, phA, takeWord, match, settleDone;
  logic              readParityBad, doneEntry;
  assign accept   = hsel & hready & htrans[1];
  assign cmdSetup = busPend & busWrite & (busAddr == REG_SETUP);
  assign cmdBlock = busPend & busWrite & (busAddr == REG_BLOCK);
  assign cmdCont  = busPend & busWrite & (busAddr == REG_CONT);
  // Phase pulses exist only while running, never on the blank slot
  assign gapped     = (idleCnt == GAP8);
  assign indexPulse = drumPulse & gapped;
  assign phA        = drumPulse & ~gapped & (state == ST_RUN)
                      & (pos != POS_BLANK);
  assign takeWord   = drumPulse & ~gapped & (state == ST_RUN)
                      & (pos == POS_BLANK);
  // On read the count has already stepped past the word just taken
  assign match      = ((sc ^ readMode) == blk[0]);
  assign settleDone = (settleCnt == 16'h0001);
  assign doneEntry  = (state == ST_RUN) & gapped;
  // Count seeded at one, so an even total leaves it set
  assign readParityBad = phA & readMode & (pos == POS_PARITY)
                         & (parityAcc ^ readBit);
  // One wait state: the data phase registers its read word
  always_ff @(posedge clk) begin
    if (rst) begin
      busPend   <= 1'b0;
      busWrite  <= 1'b0;
      busAddr   <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (busPend) begin
        busPend   <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= busWrite ? 32'h0000_0000 : readData;
      end else if (accept) begin
        busPend   <= 1'b1;
        hreadyout <= 1'b0;
        busAddr   <= haddr[7:0];
        busWrite  <= hwrite;
      end
    end
  end
  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    readData = 32'h0000_0000;
    case (busAddr)
      REG_SETUP: begin
        readData[15:0]       = coreAddr;
        readData[SETUP_READ] = readMode;
      end
      REG_BLOCK:  readData[8:0] = blk;
      REG_STATUS: begin
        readData[1:0]    = state;
        readData[STF_REQ]  = reqFlag;
        readData[STF_WEN]  = writerEn;
        readData[STF_READ] = readMode;
        readData[STF_PERR] = perr;
        readData[STF_DERR] = derr;
        readData[STF_ERR]  = perr | derr;
        readData[STF_SC]   = sc;
      end
      REG_CORE: readData[15:0] = coreAddr;
      REG_HOLD: readData[17:0] = holding;
      default:  readData = 32'h0000_0000;
    endcase
  end
  // Gap detector: saturates GAP cycles after the last drum pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      idleCnt <= GAP8;
    end else if (drumPulse) begin
      idleCnt <= 8'h00;
    end else if (!gapped) begin
      idleCnt <= idleCnt + 8'h01;
    end
  end
  // Settling delay, expiring on exactly one cycle per start
  always_ff @(posedge clk) begin
    if (rst) begin
      settleCnt <= 16'h0000;
    end else if (cmdBlock) begin
      settleCnt <= SETTLE16;
    end else if (settleCnt != 16'h0000) begin
      settleCnt <= settleCnt - 16'h0001;
    end
  end
  // Sequencer; commands override the normal advance
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (cmdSetup) begin
      state <= ST_IDLE;
    end else if (cmdCont) begin
      state <= ST_XFER;
    end else begin
      unique case (state)
        ST_IDLE: if (settleDone) state <= ST_XFER;
        ST_XFER: if (indexPulse) state <= ST_RUN;
        ST_RUN:  if (doneEntry) state <= ST_DONE;
        ST_DONE: state <= ST_DONE;
      endcase
    end
  end
  // Slot position; phase B trails phase A by one clk for rise time
  always_ff @(posedge clk) begin
    if (rst) begin
      pos <= 5'h00;
      phB <= 1'b0;
    end else begin
      phB <= phA;
      if (indexPulse || takeWord) begin
        pos <= 5'h00;
      end else if (phA) begin
        pos <= pos + 5'h01;
      end
    end
  end
  // Sector count toggles per slot since sectors interleave word by word
  always_ff @(posedge clk) begin
    if (rst) begin
      sc <= 1'b0;
    end else if (state != ST_RUN) begin
      sc <= 1'b0;
    end else if (phB && pos == POS_BLANK) begin
      sc <= ~sc;
    end
  end
  // Shift buffer, parity count and write data flop
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftBuf  <= 18'h00000;
      parityAcc <= 1'b1;
      writeFf   <= 1'b0;
    end else if (cmdBlock || cmdCont || (takeWord && !readMode)) begin
      shiftBuf  <= holding;
      parityAcc <= 1'b1;
      writeFf   <= ~holding[17];
    end else if (takeWord || indexPulse) begin
      parityAcc <= 1'b1;
    end else if (phA && readMode) begin
      if (pos != POS_PARITY) begin
        shiftBuf <= {shiftBuf[16:0], readBit};
      end
      parityAcc <= parityAcc ^ readBit;
    end else if (phA) begin
      writeFf <= ~writeFf;
      if (pos != POS_PARITY) begin
        parityAcc <= parityAcc ^ shiftBuf[17];
      end
    end else if (phB && !readMode && pos <= POS_PARITY) begin
      shiftBuf <= {shiftBuf[16:0], 1'b0};
      // Prime the flop so the next phase A toggles to the wanted bit
      writeFf  <= (pos == POS_PARITY) ? ~parityAcc : ~shiftBuf[16];
    end
  end
  // Writer gate: every step runs, only a match lets the head write
  always_ff @(posedge clk) begin
    if (rst) begin
      writerEn <= 1'b0;
    end else if (cmdSetup) begin
      writerEn <= 1'b0;
    end else if (cmdBlock) begin
      writerEn <= ~readMode & (hwdata[0] == sc);
    end else if (cmdCont) begin
      writerEn <= ~readMode & match;
    end else if (takeWord) begin
      writerEn <= ~readMode & match;
    end
  end
  // Word request; a new request wins over an acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      reqFlag <= 1'b0;
    end else if (cmdSetup) begin
      reqFlag <= ~hwdata[SETUP_READ];
    end else if (cmdBlock && !readMode && hwdata[0] == sc) begin
      reqFlag <= 1'b1;
    end else if (takeWord && match) begin
      reqFlag <= 1'b1;
    end else if (brkAck) begin
      reqFlag <= 1'b0;
    end
  end
  // Direction and mode, fixed by setup
  always_ff @(posedge clk) begin
    if (rst) begin
      readMode <= 1'b0;
      dirOut   <= 1'b1;
    end else if (cmdSetup) begin
      readMode <= hwdata[SETUP_READ];
      dirOut   <= ~hwdata[SETUP_READ];
    end
  end
  // Core address counter
  always_ff @(posedge clk) begin
    if (rst) begin
      coreAddr <= 16'h0000;
    end else if (cmdSetup) begin
      coreAddr <= hwdata[15:0];
    end else if (brkAck) begin
      coreAddr <= coreAddr + 16'h0001;
    end
  end
  // Holding buffer: from host on write, from shifter on read
  always_ff @(posedge clk) begin
    if (rst) begin
      holding <= 18'h00000;
    end else if (cmdSetup && hwdata[SETUP_READ]) begin
      holding <= 18'h00000;
    end else if (brkAck && !readMode) begin
      holding <= brkWordIn;
    end else if (takeWord && match && readMode) begin
      holding <= shiftBuf;
    end
  end
  // Block address: bumped only after a clean block
  always_ff @(posedge clk) begin
    if (rst) begin
      blk <= 9'h000;
    end else if (cmdBlock) begin
      blk <= hwdata[8:0];
    end else if (doneEntry && !perr && !derr) begin
      blk <= blk + 9'h001;
    end
  end
  // Error flags; a new error wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      perr <= 1'b0;
      derr <= 1'b0;
    end else begin
      if (readParityBad) begin
        perr <= 1'b1;
      end else if (cmdSetup || cmdCont) begin
        perr <= 1'b0;
      end
      // Late data: previous word not yet serviced when the next is due
      if (takeWord && match && reqFlag) begin
        derr <= 1'b1;
      end else if (cmdSetup || cmdCont) begin
        derr <= 1'b0;
      end
    end
  end
  // Registered error line
  always_ff @(posedge clk) begin
    if (rst) begin
      errorOut <= 1'b0;
    end else begin
      errorOut <= perr | derr;
    end
  end
  // Output groups, all fields are flops
  assign brkOut  = '{req: reqFlag, dirOut: dirOut,
                    addr: coreAddr, word: holding};
  assign headOut = '{track: blk[8:1], sector: blk[0],
                    wdata: writeFf, wen: writerEn};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_state_order: assert property (
    $changed(state) && !$past(cmdSetup) && !$past(cmdCont) |->
      (state == ST_XFER && $past(state) == ST_IDLE) ||
      (state == ST_RUN  && $past(state) == ST_XFER) ||
      (state == ST_DONE && $past(state) == ST_RUN))
    else $error("illegal state step");
  a_setup_idle: assert property (
    cmdSetup |=> state == ST_IDLE && reqFlag == !readMode)
    else $error("setup did not idle and request");
  a_no_phase: assert property (
    state != ST_RUN && !cmdBlock && !cmdCont
      |=> $stable(shiftBuf) && $stable(writeFf) && !phB)
    else $error("shifter moved outside running");
  a_addr_step: assert property (
    brkAck && !cmdSetup |=> coreAddr == $past(coreAddr) + 16'h0001)
    else $error("address counter did not step");
  a_settle_once: assert property (
    settleDone |=> !settleDone [*2])
    else $error("settle expiry repeated");
  a_settle_xfer: assert property (
    settleDone && state == ST_IDLE && !cmdSetup && !cmdCont
      |=> state == ST_XFER)
    else $error("settle end missed wait state");
  a_index_run: assert property (
    state == ST_XFER && indexPulse && !cmdSetup && !cmdCont
      |=> state == ST_RUN && pos == 5'h00)
    else $error("index did not start running");
  a_parity_prime: assert property (
    phB && !readMode && pos == POS_PARITY && !cmdBlock && !cmdCont
      |=> writeFf != $past(parityAcc))
    else $error("parity bit primed wrong");
  a_perr_set: assert property (
    readParityBad |=> perr ##1 (perr || $past(cmdSetup) || $past(cmdCont)))
    else $error("parity error lost");
  a_reload_word: assert property (
    takeWord && !readMode |=> shiftBuf == $past(holding))
    else $error("shifter not reloaded");
  a_sector_zero: assert property (
    cmdBlock && !readMode && !hwdata[0] && state != ST_RUN
      |=> reqFlag && writerEn)
    else $error("sector zero start missed");
  a_block_step: assert property (
    doneEntry && !perr && !derr && !cmdBlock
      |=> blk == $past(blk) + 9'h001 && state != ST_RUN)
    else $error("block address not stepped");
  a_sc_clear: assert property (
    state != ST_RUN |=> !sc)
    else $error("sector count not cleared");

endmodule

// ---- src/sdw_pkg.sv ----
// Constants, types and register map of the serial drum write control.
// Assumes a 25 MHz system clock and a word-wide AHB-Lite register port.
package sdw_pkg;
  // Timing
  localparam int CLK_NS     = 40;
  localparam int SETTLE_US  = 200;
  localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS     = 3400;
  localparam int GAP_CYC    = GAP_NS / CLK_NS;
  // Word format
  localparam int WORD_BITS  = 18;
  localparam int ADDR_BITS  = 16;
  localparam int BLK_BITS   = 9;
  localparam logic [4:0] POS_PARITY = 5'h12;
  localparam logic [4:0] POS_BLANK  = 5'h13;
  // Register byte offsets
  localparam logic [7:0] REG_SETUP  = 8'h00;
  localparam logic [7:0] REG_BLOCK  = 8'h04;
  localparam logic [7:0] REG_CONT   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CORE   = 8'h10;
  localparam logic [7:0] REG_HOLD   = 8'h14;
  // Field positions
  localparam int SETUP_READ = 16;
  localparam int STF_REQ    = 2;
  localparam int STF_WEN    = 3;
  localparam int STF_READ   = 4;
  localparam int STF_PERR   = 5;
  localparam int STF_DERR   = 6;
  localparam int STF_ERR    = 7;
  localparam int STF_SC     = 8;
  // Sequencing states, Gray order along the normal path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_RUN  = 2'b11,
    ST_DONE = 2'b10
  } sdw_state_e;
  // Data-break request towards the host
  typedef struct packed {
    logic                   req;
    logic                   dirOut;
    logic [ADDR_BITS-1:0]   addr;
    logic [WORD_BITS-1:0]   word;
  } sdw_brk_s;
  // Head and writer drive
  typedef struct packed {
    logic [BLK_BITS-2:0]    track;
    logic                   sector;
    logic                   wdata;
    logic                   wen;
  } sdw_head_s;
endpackage

// ---- bench/sdw_host.sv ----
// Host data-break model for the serial drum write control.
// Assumes one clk domain; answers each word request after dly cycles.
`timescale 1ns/1ps
module sdw_host
  import sdw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  sdw_brk_s         brk,
  output logic             brkAck,
  output logic      [17:0] brkWordIn
);
  // Preloaded by the bench; words delivered by reads land in got
  logic [17:0] mem [0:63];
  logic [17:0] got [0:63];
  logic [3:0]  cnt;
  // Idle word lines show the inverse, so stale data is never taken
  assign brkWordIn = brkAck ? mem[brk.addr[5:0]] : ~mem[brk.addr[5:0]];
  // One ack per request; a slow host just waits longer
  always_ff @(posedge clk) begin
    if (rst) begin
      brkAck <= 1'b0;
      cnt    <= 4'h0;
    end else begin
      brkAck <= 1'b0;
      if (brk.req && !brkAck) begin
        if (cnt == dly) begin
          brkAck <= 1'b1;
          cnt    <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
      if (brkAck && !brk.dirOut) begin
        got[brk.addr[5:0]] <= brk.word;
      end
    end
  end
endmodule

// ---- bench/serial_drum_write_control_tb.sv ----
// Self-checking bench: AHB-Lite master, drum pulse source, host model.
// Assumes the one wait state per transfer stated for the register port.
`timescale 1ns/1ps
module serial_drum_write_control_tb
  import sdw_pkg::*;
;
  localparam int SETT = 20;
  localparam int GAPC = 16;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, errorOut;
  logic        drumPulse, readBit, chk, brkAck, dRd, pA;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  dly;
  logic [17:0] brkWordIn;
  logic [17:0] w [0:7];
  logic [8:0]  blk;
  logic [31:0] rdQ [$];
  logic [31:0] rdM [$];
  logic [1:0]  bitQ [$];
  sdw_brk_s    brkOut;
  sdw_head_s   headOut;
  int          bad_count, total_checks, seed, n;

  sdw_ctrl #(.SETTLE(SETT), .GAP(GAPC)) dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .drumPulse(drumPulse), .readBit(readBit), .brkAck(brkAck),
    .brkWordIn(brkWordIn), .brkOut(brkOut), .headOut(headOut),
    .errorOut(errorOut));
  sdw_host host (.clk(clk), .rst(rst), .dly(dly), .brk(brkOut),
    .brkAck(brkAck), .brkWordIn(brkWordIn));

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Single transfer: hold address until hready, then data until hready
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rdx(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    rdQ.push_back(e);
    rdM.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  // Pulses keep three idle cycles between them for the second phase
  task automatic pulse(logic b, logic c);
    @(posedge clk);
    drumPulse <= 1'b1;
    readBit   <= b;
    chk       <= c;
    @(posedge clk);
    drumPulse <= 1'b0;
    chk       <= 1'b0;
    readBit   <= ~b;
    repeat (2) @(posedge clk);
  endtask

  // Twenty pulses: data MSB first, parity, blank
  task automatic slot(logic [17:0] d, logic p, logic en, logic rdm);
    logic b;
    for (int i = 0; i < 20; i++) begin
      b = (i < 18) ? d[17-i] : (i == 18) ? p : 1'b0;
      if (i < 19 && !rdm) bitQ.push_back({b, en});
      pulse(b, i < 19 && !rdm);
    end
  endtask

  // Read data is compared when the data phase completes
  always @(posedge clk) begin
    if (rst) begin
      dRd <= 1'b0;
    end else if (hreadyout === 1'b1) begin
      if (dRd && rdQ.size() > 0) begin
        cmp("hrdata", rdQ[0] & rdM[0], hrdata & rdM[0]);
        cmp("hresp", 32'h0, hresp);
        void'(rdQ.pop_front());
        void'(rdM.pop_front());
      end
      dRd <= hsel && htrans[1] && !hwrite;
    end
  end

  // Writer flop is looked at once the phase A edge has landed
  always @(posedge clk) begin
    pA <= chk && drumPulse;
    if (pA && bitQ.size() > 0) begin
      cmp("wdata", bitQ[0][1], headOut.wdata);
      cmp("wen", bitQ[0][0], headOut.wen);
      void'(bitQ.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {rst, hsel, hwrite, drumPulse, readBit, chk} = 6'b100000;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    dly = 4'h1;
    seed = 61;
    bad_count = 0;
    total_checks = 0;
    for (n = 0; n < 8; n++) begin
      w[n] = 18'($random(seed));
      host.mem[n+8] = w[n];
    end
    blk = 9'($random(seed)) & 9'h1fe;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdx(REG_STATUS, 32'h0, 32'hffffffff);
    rdx(8'h20, 32'h0, 32'hffffffff);
    bus(1'b1, REG_SETUP, 32'h8);
    repeat (8) @(posedge clk);
    cmp("dirOut", 1, brkOut.dirOut);
    rdx(REG_CORE, 32'h9, 32'hffff);
    rdx(REG_HOLD, w[0], 32'h3ffff);
    dly <= 4'h6;
    bus(1'b1, REG_BLOCK, blk);
    cmp("head", blk, {headOut.track, headOut.sector});
    rdx(REG_STATUS, 32'h8, 32'hb);
    rdx(REG_BLOCK, blk, 32'h1ff);
    repeat (SETT + 10) @(posedge clk);
    rdx(REG_STATUS, 32'h1, 32'h3);
    rdx(REG_CORE, 32'ha, 32'hffff);
    rdx(REG_HOLD, w[1], 32'h3ffff);
    pulse(1'b0, 1'b0);
    rdx(REG_STATUS, 32'h3, 32'h3);
    for (n = 0; n < 4; n++) begin
      slot(w[(n+1)/2], ~^w[(n+1)/2], ~n[0], 1'b0);
    end
    repeat (GAPC + 10) @(posedge clk);
    rdx(REG_STATUS, 32'h2, 32'h83);
    rdx(REG_BLOCK, blk + 9'h1, 32'h1ff);
    bus(1'b1, REG_CONT, 32'h0);
    rdx(REG_STATUS, 32'h1, 32'h3);
    bus(1'b1, REG_SETUP, 32'h10020);
    rdx(REG_STATUS, 32'h10, 32'hb3);
    cmp("dirOut", 0, brkOut.dirOut);
    rdx(REG_HOLD, 32'h0, 32'h3ffff);
    bus(1'b1, REG_BLOCK, 32'h0);
    repeat (SETT + GAPC + 10) @(posedge clk);
    pulse(1'b0, 1'b0);
    slot(w[5], ~^w[5], 1'b0, 1'b1);
    rdx(REG_STATUS, 32'h3, 32'ha3);
    slot(w[6], ^w[6], 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rdx(REG_STATUS, 32'ha3, 32'ha3);
    cmp("errorOut", 1, errorOut);
    repeat (GAPC + 10) @(posedge clk);
    rdx(REG_STATUS, 32'h82, 32'h83);
    rdx(REG_BLOCK, 32'h0, 32'h1ff);
    rdx(REG_HOLD, w[5], 32'h3ffff);
    rdx(REG_CORE, 32'h21, 32'hffff);
    cmp("stored", w[5], host.got[32]);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
